// file: logic/pesd_defines.svh
// Constants for the element status command decoder: CDB layout, codes, limits.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef PESD_DEFINES_SVH
`define PESD_DEFINES_SVH

// Command identity.
`define PESD_OPCODE          8'h9E
`define PESD_SVC_ACT         5'h17

// Byte positions within the 16-byte command descriptor block.
`define PESD_B_OPC           4'h0
`define PESD_B_SA            4'h1
`define PESD_B_RSV_FIRST     4'h2
`define PESD_B_RSV_LAST      4'h5
`define PESD_B_START_FIRST   4'h6
`define PESD_B_START_LAST    4'h9
`define PESD_B_ALLOC_FIRST   4'hA
`define PESD_B_ALLOC_LAST    4'hD
`define PESD_B_OPTS          4'hE
`define PESD_B_CTRL          4'hF

// Field masks for bits that must read as zero.
`define PESD_SA_RSV_MASK     8'hE0
`define PESD_OPTS_RSV_MASK   8'h3C
`define PESD_CTRL_CHK_MASK   8'hFC

// Filter and report category codes.
`define PESD_FILT_ALL        2'h0
`define PESD_FILT_HEALTH     2'h1
`define PESD_RPT_PHYS        2'h0
`define PESD_RPT_STOR        2'h1

// Health codes that pass the health filter.
`define PESD_HLTH_LO         8'h65
`define PESD_HLTH_HI         8'hCF
`define PESD_HLTH_DEPOP_ERR  8'hFD
`define PESD_HLTH_DEPOP_BUSY 8'hFE
`define PESD_HLTH_DEPOP_OK   8'hFF

// Parameter data sizing: header bytes and log2 of descriptor bytes.
`define PESD_HDR_BYTES       32'h20
`define PESD_DESC_SHIFT      5

// Sense data for a malformed command.
`define PESD_SK_ILLEGAL      4'h5
`define PESD_ASC_INV_CDB     8'h24
`define PESD_ASCQ_INV_CDB    8'h00

`endif

// file: logic/pesd_pkg.sv
// Types shared by the element status command decoder and its element table.
// Assumes the defines header sits beside it in logic/.
`include "pesd_defines.svh"

package pesd_pkg;

  // Sequencer states of the decoder.
  typedef enum logic [2:0] {
    PESD_IDLE,
    PESD_CHECK,
    PESD_COUNT,
    PESD_EMIT
  } pesd_state_e;

  // One entry of the element table, kept by the health bookkeeping.
  typedef struct packed {
    logic        valid;
    logic        storage;
    logic [7:0]  elemType;
    logic [7:0]  health;
    logic [31:0] id;
  } pesd_rec_s;

endpackage : pesd_pkg

// file: logic/pesd_elem_mem.sv
// Small element table memory: one write port, one read port, registered read data.
// Assumes a single clock and a synchronous caller that tolerates one cycle of read latency.
`timescale 1ns/100ps

module pesd_elem_mem #(
  parameter int WIDTH = 50,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock.
  input  wire logic             clk,
  // Write side.
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // Read side.
  input  wire logic [AW-1:0]    rdAddr,
  output      logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset; the bookkeeping marks unused entries invalid before use.
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule : pesd_elem_mem

// file: logic/pesd_decoder.sv
// Decoder and descriptor selector for the get-physical-element-status command.
// Assumes CDB bytes arrive from logic on the same clock, and that the bookkeeping
// keeps the element table in ascending order of element identifier.
`timescale 1ns/100ps

module pesd_decoder
  import pesd_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Command descriptor bytes from the initiator side.
  input  wire logic        cdbValid,
  input  wire logic        cdbFirst,
  input  wire logic [7:0]  cdbByte,
  // Element table updates from the health bookkeeping.
  input  wire logic        elemWrEn,
  input  wire logic [AW-1:0] elemWrAddr,
  input  wire pesd_rec_s   elemWrData,
  // Command outcome.
  output      logic        busy,
  output      logic        done,
  output      logic        cdbForeign,
  output      logic        checkCond,
  output      logic [3:0]  senseKey,
  output      logic [7:0]  senseAsc,
  output      logic [7:0]  senseAscq,
  output      logic [31:0] totalCount,
  output      logic [31:0] returnedCount,
  // Selected descriptors toward the data-in path.
  output      logic        descValid,
  output      logic [31:0] descId,
  output      logic [7:0]  descType,
  output      logic [7:0]  descHealth
);

  typedef struct packed {
    pesd_state_e  st;
    logic [3:0]   byteIdx;
    logic         opOk;
    logic         rsvdBad;
    logic [31:0]  startId;
    logic [31:0]  allocLen;
    logic [1:0]   filter;
    logic [1:0]   rptType;
    logic [AW:0]  scanAddr;
    logic         pend;
    logic [31:0]  total;
    logic [31:0]  ret;
    logic [31:0]  emitted;
    logic         busy;
    logic         done;
    logic         foreign;
    logic         checkCond;
    logic [3:0]   senseKey;
    logic [7:0]   senseAsc;
    logic [7:0]   senseAscq;
    logic         descValid;
    logic [31:0]  descId;
    logic [7:0]   descType;
    logic [7:0]   descHealth;
  } pesd_regs_s;

  pesd_regs_s r_ff;
  pesd_regs_s nxt_r;
  logic [1:0] rstSync_ff;
  logic       rstN;
  pesd_rec_s  rdRec;
  logic [31:0] fitCnt;
  logic [3:0] idx;

  // Decide whether one table entry belongs in the element descriptors list.
  function automatic logic qualifies(input pesd_rec_s rec, input logic [31:0] startId,
                                     input logic [1:0] filter, input logic [1:0] rptType);
    logic hOk;
    logic tOk;
    hOk = (rec.health >= `PESD_HLTH_LO && rec.health <= `PESD_HLTH_HI) ||
          (rec.health >= `PESD_HLTH_DEPOP_ERR);
    hOk = (filter == `PESD_FILT_ALL) || hOk;
    tOk = (rptType == `PESD_RPT_PHYS) || rec.storage;
    return rec.valid && (rec.id >= startId) && hOk && tOk;
  endfunction : qualifies

  // Reset is released through two flops so every state flop leaves reset on one edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  pesd_elem_mem #(
    .WIDTH ($bits(pesd_rec_s)),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk    (clk),
    .wrEn   (elemWrEn),
    .wrAddr (elemWrAddr),
    .wrData (elemWrData),
    .rdAddr (r_ff.scanAddr[AW-1:0]),
    .rdData (rdRec)
  );

  // Descriptors that fit after the header within the allocation length.
  assign fitCnt = (r_ff.allocLen < `PESD_HDR_BYTES) ? 32'h0 :
                  ((r_ff.allocLen - `PESD_HDR_BYTES) >> `PESD_DESC_SHIFT);
  assign idx = cdbFirst ? `PESD_B_OPC : r_ff.byteIdx;

  // Next-state logic for the whole decoder. The table may change while a scan runs;
  // counts of two identical commands may then differ, which the protocol allows.
  always_comb begin
    nxt_r           = r_ff;
    nxt_r.done      = 1'b0;
    nxt_r.foreign   = 1'b0;
    nxt_r.descValid = 1'b0;
    case (r_ff.st)
      PESD_IDLE: begin
        if (cdbValid) begin
          nxt_r.byteIdx = idx + 4'h1;
          if (idx == `PESD_B_OPC) begin
            nxt_r.opOk    = (cdbByte == `PESD_OPCODE);
            nxt_r.rsvdBad = 1'b0;
          end else if (idx == `PESD_B_SA) begin
            nxt_r.opOk    = r_ff.opOk && (cdbByte[4:0] == `PESD_SVC_ACT);
            nxt_r.rsvdBad = |(cdbByte & `PESD_SA_RSV_MASK);
          end else if (idx >= `PESD_B_RSV_FIRST && idx <= `PESD_B_RSV_LAST) begin
            nxt_r.rsvdBad = r_ff.rsvdBad || (|cdbByte);
          end else if (idx >= `PESD_B_START_FIRST && idx <= `PESD_B_START_LAST) begin
            nxt_r.startId = {r_ff.startId[23:0], cdbByte};
          end else if (idx >= `PESD_B_ALLOC_FIRST && idx <= `PESD_B_ALLOC_LAST) begin
            nxt_r.allocLen = {r_ff.allocLen[23:0], cdbByte};
          end else if (idx == `PESD_B_OPTS) begin
            nxt_r.filter  = cdbByte[7:6];
            nxt_r.rptType = cdbByte[1:0];
            nxt_r.rsvdBad = r_ff.rsvdBad || (|(cdbByte & `PESD_OPTS_RSV_MASK));
          end else begin
            nxt_r.rsvdBad = r_ff.rsvdBad || (|(cdbByte & `PESD_CTRL_CHK_MASK));
            nxt_r.byteIdx = `PESD_B_OPC;
            nxt_r.st      = PESD_CHECK;
            nxt_r.busy    = 1'b1;
          end
        end
      end
      PESD_CHECK: begin
        if (!r_ff.opOk) begin
          // Some other command: leave it to the decoder that owns it.
          nxt_r.foreign = 1'b1;
          nxt_r.busy    = 1'b0;
          nxt_r.st      = PESD_IDLE;
        end else if (r_ff.rsvdBad || r_ff.filter[1] || r_ff.rptType[1]) begin
          nxt_r.checkCond = 1'b1;
          nxt_r.senseKey  = `PESD_SK_ILLEGAL;
          nxt_r.senseAsc  = `PESD_ASC_INV_CDB;
          nxt_r.senseAscq = `PESD_ASCQ_INV_CDB;
          nxt_r.done      = 1'b1;
          nxt_r.busy      = 1'b0;
          nxt_r.st        = PESD_IDLE;
        end else begin
          nxt_r.checkCond = 1'b0;
          nxt_r.senseKey  = 4'h0;
          nxt_r.senseAsc  = 8'h00;
          nxt_r.senseAscq = 8'h00;
          nxt_r.total     = 32'h0;
          nxt_r.emitted   = 32'h0;
          nxt_r.scanAddr  = '0;
          nxt_r.pend      = 1'b0;
          nxt_r.st        = PESD_COUNT;
        end
      end
      PESD_COUNT, PESD_EMIT: begin
        // Read issued at scanAddr; data for the previous address arrives now.
        if (r_ff.scanAddr < (AW+1)'(DEPTH)) begin
          nxt_r.scanAddr = r_ff.scanAddr + (AW+1)'(1);
          nxt_r.pend     = 1'b1;
        end else begin
          nxt_r.pend     = 1'b0;
        end
        if (r_ff.pend && qualifies(rdRec, r_ff.startId, r_ff.filter, r_ff.rptType)) begin
          if (r_ff.st == PESD_COUNT) begin
            nxt_r.total = r_ff.total + 32'h1;
          end else if (r_ff.emitted < r_ff.ret) begin
            // Table order is ascending, so emission order is ascending too.
            nxt_r.descValid  = 1'b1;
            nxt_r.descId     = rdRec.id;
            nxt_r.descType   = rdRec.elemType;
            nxt_r.descHealth = rdRec.health;
            nxt_r.emitted    = r_ff.emitted + 32'h1;
          end
        end
        if (r_ff.scanAddr == (AW+1)'(DEPTH) && !r_ff.pend) begin
          nxt_r.scanAddr = '0;
          if (r_ff.st == PESD_COUNT) begin
            nxt_r.ret = (r_ff.total < fitCnt) ? r_ff.total : fitCnt;
            nxt_r.st  = PESD_EMIT;
          end else begin
            nxt_r.done = 1'b1;
            nxt_r.busy = 1'b0;
            nxt_r.st   = PESD_IDLE;
          end
        end
      end
      default: begin
        nxt_r.st   = PESD_IDLE;
        nxt_r.busy = 1'b0;
      end
    endcase
  end

  // State register on the synchronised reset.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      r_ff    <= '0;
      r_ff.st <= PESD_IDLE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs come straight from the state register.
  assign busy          = r_ff.busy;
  assign done          = r_ff.done;
  assign cdbForeign    = r_ff.foreign;
  assign checkCond     = r_ff.checkCond;
  assign senseKey      = r_ff.senseKey;
  assign senseAsc      = r_ff.senseAsc;
  assign senseAscq     = r_ff.senseAscq;
  assign totalCount    = r_ff.total;
  assign returnedCount = r_ff.ret;
  assign descValid     = r_ff.descValid;
  assign descId        = r_ff.descId;
  assign descType      = r_ff.descType;
  assign descHealth    = r_ff.descHealth;

endmodule : pesd_decoder

// file: verif/pesd_decoder_props.sv
// Concurrent checks on the element status decoder outcome and descriptor ports.
// Assumes binding onto pesd_decoder with every input named after its port.
`timescale 1ns/100ps

module pesd_decoder_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset_n,
  // Outcome and descriptors.
  input wire logic        busy,
  input wire logic        done,
  input wire logic        cdbForeign,
  input wire logic        checkCond,
  input wire logic [3:0]  senseKey,
  input wire logic [7:0]  senseAsc,
  input wire logic [7:0]  senseAscq,
  input wire logic [31:0] totalCount,
  input wire logic [31:0] returnedCount,
  input wire logic        descValid,
  input wire logic [31:0] descId
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [31:0] cnt_ff;
  logic [31:0] lastId_ff;
  logic        seen_ff;

  // Tally and seen flag restart at each completion, so commands never mix.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff    <= 32'h0;
      lastId_ff <= 32'h0;
      seen_ff   <= 1'b0;
    end else if (done) begin
      cnt_ff  <= 32'h0;
      seen_ff <= 1'b0;
    end else if (descValid) begin
      cnt_ff    <= cnt_ff + 32'h1;
      lastId_ff <= descId;
      seen_ff   <= 1'b1;
    end
  end

  sequence s_close;
    busy ##[1:16] done;
  endsequence

  property p_pulse; done |=> !done; endproperty
  property p_fin; done |-> !busy && $past(busy); endproperty
  property p_fgn; cdbForeign |-> !done && !busy; endproperty
  property p_sense;
    done && checkCond |-> senseKey == 4'h5 && senseAsc == 8'h24 && senseAscq == 8'h00;
  endproperty
  property p_clean; done && !checkCond |-> senseKey == 4'h0; endproperty
  property p_bound; done |-> returnedCount <= totalCount; endproperty
  property p_count; done && !checkCond |-> returnedCount == cnt_ff; endproperty
  property p_order; descValid && seen_ff |-> descId > lastId_ff; endproperty
  property p_desc; descValid |-> s_close; endproperty

  a_pulse: assert property (p_pulse) else $error("done wider than one cycle");
  a_fin: assert property (p_fin) else $error("done without busy before it");
  a_fgn: assert property (p_fgn) else $error("foreign command completed");
  a_sense: assert property (p_sense) else $error("wrong sense on rejection");
  a_clean: assert property (p_clean) else $error("sense set on good command");
  a_bound: assert property (p_bound) else $error("returned above total");
  a_count: assert property (p_count) else $error("returned differs from sent");
  a_order: assert property (p_order) else $error("descriptors out of order");
  a_desc: assert property (p_desc) else $error("descriptor outside command");
endmodule : pesd_decoder_props

// file: verif/pesd_host.sv
// Initiator model that hands command descriptor bytes to the decoder.
// Assumes the bench calls send and that busy comes from the decoder.
`timescale 1ns/100ps

module pesd_host (
  // Clock and decoder state.
  input  wire logic       clk,
  input  wire logic       busy,
  // Command byte stream.
  output      logic       cdbValid,
  output      logic       cdbFirst,
  output      logic [7:0] cdbByte
);
  // Idle lines before the first command.
  initial begin
    cdbValid = 1'b0;
    cdbFirst = 1'b0;
    cdbByte  = 8'h00;
  end

  // Bytes go MSB first; gap inserts idle cycles to act as a slow initiator.
  // Late reports that busy never fell within the bound, so the bench can fail the run.
  task automatic send(input logic [127:0] c, input int gap, output bit late);
    for (int t = 0; t < 64 && busy; t++) @(posedge clk);
    late = (busy !== 1'b0);
    for (int i = 0; i < 16; i++) begin
      repeat (gap) begin
        @(posedge clk);
        #1;
        cdbValid = 1'b0;
        cdbByte  = ~cdbByte; // Stale data must not look valid.
      end
      @(posedge clk);
      #1;
      cdbValid = 1'b1;
      cdbFirst = (i == 0);
      cdbByte  = c[127-8*i -: 8];
    end
    @(posedge clk);
    #1;
    cdbValid = 1'b0;
    cdbFirst = 1'b0;
    cdbByte  = ~cdbByte;
  endtask : send
endmodule : pesd_host

// file: verif/tb.sv
// Self-checking bench for the element status decoder.
// Assumes pesd_decoder with DEPTH 8 and an eight-entry sorted element table.
`timescale 1ns/100ps

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb;
  import pesd_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cdbValid, cdbFirst, busy, done, cdbForeign, checkCond, descValid;
  logic elemWrEn = 1'b0;
  logic [2:0] elemWrAddr = 3'h0;
  pesd_rec_s elemWrData = '0;
  logic [7:0] cdbByte, senseAsc, senseAscq, descType, descHealth;
  logic [3:0] senseKey;
  logic [31:0] totalCount, returnedCount, descId;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] hl [8] = '{8'h64, 8'h65, 8'hCF, 8'hD0, 8'hFC, 8'hFD, 8'hFE, 8'hFF};

  // Clock at 200 MHz.
  always #2.5 clk = ~clk;

  pesd_host pesd_host_inst (.clk, .busy, .cdbValid, .cdbFirst, .cdbByte);
  pesd_decoder pesd_decoder_inst (.clk, .reset_n, .cdbValid, .cdbFirst, .cdbByte,
    .elemWrEn, .elemWrAddr, .elemWrData, .busy, .done, .cdbForeign, .checkCond,
    .senseKey, .senseAsc, .senseAscq, .totalCount, .returnedCount, .descValid,
    .descId, .descType, .descHealth);

  function automatic logic [31:0] id(int i); return 32'(10 * (i + 1)); endfunction : id
  // Entry 3 is left invalid; odd entries are storage elements; each type is its slot.
  function automatic bit qual(int i, logic [1:0] f, r, logic [31:0] st);
    return i != 3 && id(i) >= st && (r == 2'h0 || i[0]) &&
           (f == 2'h0 || (hl[i] >= 8'h65 && hl[i] <= 8'hCF) || hl[i] >= 8'hFD);
  endfunction : qual
  function automatic logic [127:0] mk(logic [1:0] f, r, logic [31:0] st, al);
    return {8'h9E, 8'h17, 32'h0, st, al, f, 4'h0, r, 8'h00};
  endfunction : mk

  task automatic summarize;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Sends one command and judges descriptors, counts and sense against the rules.
  task automatic run(input logic [127:0] c, input bit bad, fgn, input int gap);
    logic [31:0] tot, ret, n;
    int k;
    bit fin;
    bit late;
    tot = 0;
    for (int i = 0; i < 8; i++) if (qual(i, c[15:14], c[9:8], c[79:48])) tot++;
    ret = (c[47:16] < 32) ? 32'h0 : (c[47:16] - 32) >> 5;
    if (ret > tot) ret = tot;
    pesd_host_inst.send(c, gap, late);
    `CHK(busy, 1'b1)
    n = 0;
    k = 0;
    fin = 0;
    for (int t = 0; t < 100 && !fin; t++) begin
      @(posedge clk);
      #1;
      if (descValid === 1'b1) begin
        while (k < 7 && !qual(k, c[15:14], c[9:8], c[79:48])) k++;
        `CHK(descId, id(k))
        `CHK(descHealth, hl[k])
        `CHK(descType, 8'(k))
        k++;
        n++;
      end
      if (done === 1'b1 || cdbForeign === 1'b1) fin = 1;
    end
    if (!fin || late) begin
      fails++;
      summarize();
    end
    `CHK(cdbForeign, fgn)
    if (!fgn) begin
      `CHK(checkCond, bad)
      if (bad) `CHK({senseKey, senseAsc, senseAscq}, 20'h52400)
      else begin
        `CHK(totalCount, tot)
        `CHK(returnedCount, ret)
        `CHK(n, ret)
      end
    end
  endtask : run

  // Filter and report category codes 0 and 1 in all four pairings.
  task automatic s_codes;
    for (int m = 0; m < 4; m++) run(mk(2'(m >> 1), 2'(m & 1), 0, 32'hFFFF), 0, 0, m);
  endtask : s_codes

  // Start identifier and transfer limit at their boundaries.
  task automatic s_limits;
    run(mk(0, 0, 32'd30, 32'd96), 0, 0, 0);
    run(mk(0, 0, 32'd31, 32'd63), 0, 0, 0);
    run(mk(1, 0, 32'd81, 32'd31), 0, 0, 0);
  endtask : s_limits

  // Reserved codes and nonzero reserved bits, then foreign commands.
  task automatic s_reject;
    int b [6] = '{15, 9, 104, 119, 10, 7};
    for (int i = 0; i < 6; i++) run(mk(0, 0, 0, 32'hFFFF) | (128'h1 << b[i]), 1, 0, 0);
    run(mk(0, 0, 0, 32'hFFFF) ^ (128'h1 << 120), 0, 1, 0);
    run(mk(0, 0, 0, 32'hFFFF) ^ (128'h1 << 112), 0, 1, 0);
  endtask : s_reject

  // Reset in mid-scan clears the outcome; a command after release still completes.
  task automatic s_reset;
    bit late;
    pesd_host_inst.send(mk(0, 0, 0, 32'hFFFF), 0, late);
    if (late) begin
      fails++;
      summarize();
    end
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b0;
    @(posedge clk);
    #1;
    `CHK({busy, done, descValid, totalCount, returnedCount}, 67'h0)
    reset_n = 1'b1;
    // The internal copy of reset lags two edges, so the first byte waits past it.
    repeat (2) @(posedge clk);
    run(mk(1, 1, 0, 32'hFFFF), 0, 0, 0);
  endtask : s_reset

  // Reset, table load, then scenarios.
  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      #1;
      elemWrEn = 1'b1;
      elemWrAddr = 3'(i);
      elemWrData = '{i != 3, i[0], 8'(i), hl[i], id(i)};
      @(posedge clk);
    end
    #1;
    elemWrEn = 1'b0;
    s_codes();
    s_limits();
    s_reject();
    s_reset();
    summarize();
  end
endmodule : tb

bind pesd_decoder pesd_decoder_props pesd_decoder_props_inst (.clk, .reset_n, .busy,
  .done, .cdbForeign, .checkCond, .senseKey, .senseAsc, .senseAscq, .totalCount,
  .returnedCount, .descValid, .descId);
